// ===== pkg/rffc_consts.vh
// Register offsets, field positions, reset values and framing constants for the frame format block.
`ifndef RFFC_CONSTS_VH
`define RFFC_CONSTS_VH

`define RFFC_ADDR_W 16
`define RFFC_OFS_TX_PATH_POWER_OFF 16'h2206
`define RFFC_OFS_TX_PATH_POWER_UP 16'h2207
`define RFFC_OFS_PACKET_FORMAT_ONE 16'h2211
`define RFFC_OFS_START_FRAME_DELIMITER 16'h2212
`define RFFC_OFS_TX_FORMAT 16'h2213

`define RFFC_RST_TX_PATH_POWER_OFF 8'h00
`define RFFC_RST_TX_PATH_POWER_UP 8'hFB
`define RFFC_RST_PACKET_FORMAT_ONE 8'h02
`define RFFC_RST_START_FRAME_DELIMITER 8'hA7
`define RFFC_RST_TX_FORMAT 8'h02

`define RFFC_DAC_BIT 0
`define RFFC_UPMIX_HI 2
`define RFFC_UPMIX_LO 1
`define RFFC_RX_RATE_HI 7
`define RFFC_RX_RATE_LO 6
`define RFFC_TX_RATE_HI 5
`define RFFC_TX_RATE_LO 4
`define RFFC_PREAMBLE_HI 3
`define RFFC_PREAMBLE_LO 0

`define RFFC_PREAMBLE_BASE 5'h06
`define RFFC_PREAMBLE_SYM 4'h0

`endif

// ===== src/rffc_top.v
// Frame format and transmit path power configuration with delimiter framing on the symbol streams.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "rffc_consts.vh"
// Summary of operation
// [RULE1] Up-mixer is enabled while its two-bit power-up field is nonzero; field resets to one.
// [RULE2] Bit 0 is the DAC power-up control, combined with the power-down bit; resets to one.
// [RULE3] Off=1,on=1 modem controls DAC; off=0,on=1 forces down; otherwise forced up.
// [RULE4] Receive rate field bits 7:6 reset 00: 0 base, 1 adds 500k, 2/3 extended set.
// [RULE5] Transmit rate field bits 5:4 reset 00: 0 base, 1 adds 500k, higher adds 1M.
// [RULE6] Receive preamble length field bits 3:0 reset 0010; length spans 6 to 21 symbols.
// [RULE7] Start-of-frame delimiter is two four-bit symbols forming byte 0xA7.
// [RULE8] Transmitter sends the low delimiter symbol first, then the high symbol.
// [RULE9] Frame start only after full preamble then both delimiter symbols in order.
module rffc_top (
   input wire clk_sys,
   input wire rst,
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire modem_dac_request,
   input wire rx_sym_valid,
   input wire [3:0] rx_sym,
   input wire tx_frame_start,
   input wire tx_sym_ready,
   output reg tx_sym_valid,
   output reg [3:0] tx_sym,
   output reg tx_delimiter_done,
   output reg tx_busy,
   output reg rx_frame_start,
   output reg tx_upmixer_enable,
   output reg dac_enable,
   output reg [1:0] rx_rate_select,
   output reg rx_accept_500k,
   output reg rx_accept_1m,
   output reg [1:0] tx_rate_select,
   output reg tx_allow_500k,
   output reg tx_allow_1m
);

   localparam RX_HUNT = 2'b00;
   localparam RX_HIGH = 2'b10;

   localparam SLOT_POWER_OFF = 3'h0;
   localparam SLOT_POWER_UP = 3'h1;
   localparam SLOT_FORMAT_ONE = 3'h2;
   localparam SLOT_DELIMITER = 3'h3;
   localparam SLOT_TX_FORMAT = 3'h4;
   localparam SLOT_NONE = 3'h7;

   localparam TX_IDLE = 2'b00;
   localparam TX_PREAMBLE = 2'b01;
   localparam TX_SFD_LOW = 2'b10;
   localparam TX_SFD_HIGH = 2'b11;

   reg [7:0] tx_path_power_off;
   reg [7:0] tx_path_power_up;
   reg [7:0] packet_format_one;
   reg [7:0] start_frame_delimiter;
   // The transmit preamble length has its own byte so both directions may differ.
   reg [7:0] tx_format;
   reg [1:0] rx_state;
   reg [4:0] rx_zero_count;
   reg [1:0] tx_state;
   reg [4:0] tx_count;
   reg [7:0] next_rdata;
   wire [1:0] tx_upmixer_power_on;
   wire dac_power_on;
   wire dac_power_off;
   wire [3:0] rx_preamble_length;
   wire [3:0] tx_preamble_length;
   wire [4:0] rx_need;
   wire [4:0] tx_need;
   wire [1:0] rx_caps;
   wire [1:0] tx_caps;
   wire tx_take;
   wire [2:0] reg_slot;

   // Returns {adds 1M, adds 500k} for a rate field; both directions decode alike.
   function [1:0] rffc_rate_caps;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: rffc_rate_caps = 2'b00;
            2'h1: rffc_rate_caps = 2'b01;
            default: rffc_rate_caps = 2'b11;
         endcase
      end
   endfunction

   // Preamble symbols counted from the field; zero maps to the shortest length.
   function [4:0] rffc_preamble_symbols;
      input [3:0] field;
      begin
         rffc_preamble_symbols = {1'b0, field} + `RFFC_PREAMBLE_BASE;
      end
   endfunction

   // Writes and reads share one address decode so they can never disagree on a register.
   function [2:0] rffc_reg_slot;
      input [`RFFC_ADDR_W-1:0] addr;
      begin
         case (addr)
            `RFFC_OFS_TX_PATH_POWER_OFF: rffc_reg_slot = SLOT_POWER_OFF;
            `RFFC_OFS_TX_PATH_POWER_UP: rffc_reg_slot = SLOT_POWER_UP;
            `RFFC_OFS_PACKET_FORMAT_ONE: rffc_reg_slot = SLOT_FORMAT_ONE;
            `RFFC_OFS_START_FRAME_DELIMITER: rffc_reg_slot = SLOT_DELIMITER;
            `RFFC_OFS_TX_FORMAT: rffc_reg_slot = SLOT_TX_FORMAT;
            default: rffc_reg_slot = SLOT_NONE;
         endcase
      end
   endfunction

   assign tx_upmixer_power_on = tx_path_power_up[`RFFC_UPMIX_HI:`RFFC_UPMIX_LO];
   assign dac_power_on = tx_path_power_up[`RFFC_DAC_BIT];
   assign dac_power_off = tx_path_power_off[`RFFC_DAC_BIT];
   assign rx_preamble_length = packet_format_one[`RFFC_PREAMBLE_HI:`RFFC_PREAMBLE_LO];
   assign tx_preamble_length = tx_format[`RFFC_PREAMBLE_HI:`RFFC_PREAMBLE_LO];
   assign rx_need = rffc_preamble_symbols(rx_preamble_length); // [RULE6]
   assign tx_need = rffc_preamble_symbols(tx_preamble_length);
   assign rx_caps = rffc_rate_caps(packet_format_one[`RFFC_RX_RATE_HI:`RFFC_RX_RATE_LO]); // [RULE4]
   assign tx_caps = rffc_rate_caps(packet_format_one[`RFFC_TX_RATE_HI:`RFFC_TX_RATE_LO]); // [RULE5]
   assign tx_take = tx_sym_valid & tx_sym_ready;
   assign reg_slot = rffc_reg_slot(reg_addr);

   // Register writes; all bytes are plain read/write storage.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_path_power_off <= `RFFC_RST_TX_PATH_POWER_OFF;
         tx_path_power_up <= `RFFC_RST_TX_PATH_POWER_UP; // [RULE1] [RULE2]
         packet_format_one <= `RFFC_RST_PACKET_FORMAT_ONE; // [RULE4] [RULE5] [RULE6]
         start_frame_delimiter <= `RFFC_RST_START_FRAME_DELIMITER; // [RULE7]
         tx_format <= `RFFC_RST_TX_FORMAT;
      end else if (reg_wr) begin
         case (reg_slot)
            SLOT_POWER_OFF: tx_path_power_off <= reg_wdata;
            SLOT_POWER_UP: tx_path_power_up <= reg_wdata;
            SLOT_FORMAT_ONE: packet_format_one <= reg_wdata;
            SLOT_DELIMITER: start_frame_delimiter <= reg_wdata;
            SLOT_TX_FORMAT: tx_format <= reg_wdata;
            default: tx_format <= tx_format;
         endcase
      end
   end

   // Unmapped addresses read as zero.
   always @* begin
      case (reg_slot)
         SLOT_POWER_OFF: next_rdata = tx_path_power_off;
         SLOT_POWER_UP: next_rdata = tx_path_power_up;
         SLOT_FORMAT_ONE: next_rdata = packet_format_one;
         SLOT_DELIMITER: next_rdata = start_frame_delimiter;
         SLOT_TX_FORMAT: next_rdata = tx_format;
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Power and rate controls are registered so every output comes from a flop.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_upmixer_enable <= 1'b1;
         dac_enable <= 1'b1;
         rx_rate_select <= 2'h0;
         rx_accept_500k <= 1'b0;
         rx_accept_1m <= 1'b0;
         tx_rate_select <= 2'h0;
         tx_allow_500k <= 1'b0;
         tx_allow_1m <= 1'b0;
      end else begin
         tx_upmixer_enable <= |tx_upmixer_power_on; // [RULE1]
         // Reset leaves the DAC up; the first edge after release applies the decode of the reset bits.
         if (dac_power_off & dac_power_on) begin
            dac_enable <= modem_dac_request; // [RULE3]
         end else if (!dac_power_off & dac_power_on) begin
            dac_enable <= 1'b0; // [RULE2] [RULE3]
         end else begin
            dac_enable <= 1'b1; // [RULE3]
         end
         rx_rate_select <= packet_format_one[`RFFC_RX_RATE_HI:`RFFC_RX_RATE_LO];
         rx_accept_500k <= rx_caps[0]; // [RULE4]
         rx_accept_1m <= rx_caps[1]; // [RULE4]
         tx_rate_select <= packet_format_one[`RFFC_TX_RATE_HI:`RFFC_TX_RATE_LO];
         tx_allow_500k <= tx_caps[0]; // [RULE5]
         tx_allow_1m <= tx_caps[1]; // [RULE5]
      end
   end

   // Receive hunt. A wrong symbol restarts the search, but a zero still counts as preamble
   // so a frame whose start overlaps a failed attempt is not missed.
   // A longer preamble than programmed is accepted, trading strictness for tolerance of early lock.
   // A delimiter whose low symbol is zero can never be found, since zeros count as preamble.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_state <= RX_HUNT;
         rx_zero_count <= 5'h00;
         rx_frame_start <= 1'b0;
      end else begin
         rx_frame_start <= 1'b0;
         if (rx_sym_valid) begin
            case (rx_state)
               RX_HUNT: begin
                  if (rx_sym == `RFFC_PREAMBLE_SYM) begin
                     // The count saturates so a long run of zeros cannot wrap and look short.
                     if (rx_zero_count != 5'h1F) begin
                        rx_zero_count <= rx_zero_count + 5'h01;
                     end
                  end else if (rx_sym == start_frame_delimiter[3:0] && rx_zero_count >= rx_need) begin
                     rx_state <= RX_HIGH; // [RULE6] [RULE9]
                     rx_zero_count <= 5'h00;
                  end else begin
                     rx_zero_count <= 5'h00;
                  end
               end
               RX_HIGH: begin
                  if (rx_sym == start_frame_delimiter[7:4]) begin
                     rx_frame_start <= 1'b1; // [RULE9]
                     rx_zero_count <= 5'h00;
                  end else if (rx_sym == `RFFC_PREAMBLE_SYM) begin
                     rx_zero_count <= 5'h01;
                  end else begin
                     rx_zero_count <= 5'h00;
                  end
                  rx_state <= RX_HUNT;
               end
               default: begin
                  rx_state <= RX_HUNT;
                  rx_zero_count <= 5'h00;
               end
            endcase
         end
      end
   end

   // Transmit framing: preamble zeros, then the delimiter low symbol, then the high one.
   // Each symbol is held on the port until the modem takes it.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_state <= TX_IDLE;
         tx_count <= 5'h00;
         tx_sym_valid <= 1'b0;
         tx_sym <= 4'h0;
         tx_delimiter_done <= 1'b0;
         tx_busy <= 1'b0;
      end else begin
         tx_delimiter_done <= 1'b0;
         case (tx_state)
            TX_IDLE: begin
               // A start request while a sequence runs is dropped, not queued.
               if (tx_frame_start) begin
                  tx_state <= TX_PREAMBLE;
                  tx_count <= 5'h01;
                  tx_sym_valid <= 1'b1;
                  tx_sym <= `RFFC_PREAMBLE_SYM;
                  tx_busy <= 1'b1;
               end
            end
            TX_PREAMBLE: begin
               if (tx_take) begin
                  if (tx_count >= tx_need) begin
                     tx_state <= TX_SFD_LOW;
                     tx_sym <= start_frame_delimiter[3:0]; // [RULE7] [RULE8]
                  end else begin
                     tx_count <= tx_count + 5'h01;
                  end
               end
            end
            TX_SFD_LOW: begin
               if (tx_take) begin
                  tx_state <= TX_SFD_HIGH;
                  tx_sym <= start_frame_delimiter[7:4]; // [RULE8]
               end
            end
            TX_SFD_HIGH: begin
               if (tx_take) begin
                  tx_state <= TX_IDLE;
                  tx_sym_valid <= 1'b0;
                  tx_sym <= 4'h0;
                  tx_delimiter_done <= 1'b1;
                  tx_busy <= 1'b0;
               end
            end
            default: begin
               tx_state <= TX_IDLE;
               tx_sym_valid <= 1'b0;
               tx_busy <= 1'b0;
            end
         endcase
      end
   end

endmodule // rffc_top

// ===== tb/rffc_chk_asserts.sv
// Concurrent checks on the ports of the frame format block.
`timescale 1ns/1ps
module rffc_chk (
   input logic clk_sys,
   input logic rst,
   input logic [15:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic rx_sym_valid,
   input logic tx_frame_start,
   input logic tx_sym_ready,
   input logic tx_sym_valid,
   input logic [3:0] tx_sym,
   input logic tx_delimiter_done,
   input logic tx_busy,
   input logic rx_frame_start,
   input logic tx_upmixer_enable,
   input logic dac_enable,
   input logic [1:0] tx_rate_select,
   input logic tx_allow_1m
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Stale read data would let software see a register it never asked for.
   rd_slot_a: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("read data outside its slot");
   tx_start_a: assert property (tx_frame_start && !tx_busy |=> tx_busy && tx_sym_valid && tx_sym == 4'h0)
      else $error("transmit start not answered");
   tx_hold_a: assert property (tx_sym_valid && !tx_sym_ready |=> tx_sym_valid && $stable(tx_sym))
      else $error("symbol dropped while stalled");
   tx_done_a: assert property (tx_delimiter_done |-> !tx_busy && !tx_sym_valid && $past(tx_sym_ready)
      ##1 !tx_delimiter_done)
      else $error("bad delimiter done pulse");
   rx_pulse_a: assert property (rx_frame_start |-> $past(rx_sym_valid) ##1 !rx_frame_start)
      else $error("bad frame start pulse");
   upmix_off_a: assert property (reg_wr && reg_addr == 16'h2207 && reg_wdata[2:1] == 2'b00 ##1 !reg_wr
      |=> !tx_upmixer_enable)
      else $error("up-mixer still enabled");
   dac_up_a: assert property (reg_wr && reg_addr == 16'h2207 && !reg_wdata[0] ##1 !reg_wr |=> dac_enable)
      else $error("DAC not forced up");
   tx_rate_a: assert property (reg_wr && reg_addr == 16'h2211 && reg_wdata[5:4] == 2'b10 ##1 !reg_wr
      |=> tx_allow_1m && tx_rate_select == 2'b10)
      else $error("transmit rate not applied");
endmodule // rffc_chk

bind rffc_top rffc_chk u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_sym_valid,
   .tx_frame_start, .tx_sym_ready, .tx_sym_valid, .tx_sym, .tx_delimiter_done, .tx_busy, .rx_frame_start,
   .tx_upmixer_enable, .dac_enable, .tx_rate_select, .tx_allow_1m);

// ===== tb/tb.sv
// Self-checking bench for the frame format block.
`timescale 1ns/1ps
module tb;
   logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, modem_dac_request = 0;
   logic rx_sym_valid = 0, tx_frame_start = 0, tx_sym_ready = 0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic [3:0] rx_sym = 4'h0;
   logic [7:0] reg_rdata;
   logic [3:0] tx_sym;
   logic [1:0] rx_rate_select, tx_rate_select;
   logic tx_sym_valid, tx_delimiter_done, tx_busy, rx_frame_start, tx_upmixer_enable, dac_enable;
   logic rx_accept_500k, rx_accept_1m, tx_allow_500k, tx_allow_1m;
   int bad_count = 0, n_tests = 0;
   logic [3:0] got [0:31];
   rffc_top u_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .modem_dac_request,
      .rx_sym_valid, .rx_sym, .tx_frame_start, .tx_sym_ready, .tx_sym_valid, .tx_sym, .tx_delimiter_done,
      .tx_busy, .rx_frame_start, .tx_upmixer_enable, .dac_enable, .rx_rate_select, .rx_accept_500k,
      .rx_accept_1m, .tx_rate_select, .tx_allow_500k, .tx_allow_1m);
   always #25 clk_sys = ~clk_sys;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // Ready toggles every cycle so each symbol must hold through a stall.
   task automatic tx_run(input logic [3:0] f);
      int cnt, n;
      cnt = 0;
      n = f + 6;
      wr(16'h2213, {4'h0, f});
      @(posedge clk_sys);
      tx_frame_start <= 1'b1;
      for (int k = 0; k < 80 && cnt < n + 2; k++) begin
         @(posedge clk_sys);
         tx_frame_start <= (k == 3);
         tx_sym_ready <= k[0];
         #1 if (tx_sym_valid && tx_sym_ready) begin
            got[cnt] = tx_sym;
            cnt++;
         end
      end
      @(posedge clk_sys);
      tx_sym_ready <= 1'b0;
      #1 chk(tx_delimiter_done, 1);
      chk(cnt, n + 2);
      for (int i = 0; i < n; i++) chk(got[i], 0);
      chk(got[n], 7);
      chk(got[n + 1], 8'h0A);
      @(posedge clk_sys);
      #1 chk({tx_sym_valid, tx_busy}, 0);
   endtask
   task automatic rx_case(input logic [3:0] f, input int n, input logic [3:0] lo, hi, input logic e);
      wr(16'h2211, {4'hF, f});
      for (int i = 0; i < n + 2; i++) begin
         @(posedge clk_sys);
         rx_sym_valid <= 1'b1;
         rx_sym <= (i < n) ? 4'h0 : ((i == n) ? lo : hi);
      end
      @(posedge clk_sys);
      rx_sym_valid <= 1'b0;
      rx_sym <= ~hi;
      #1 chk(rx_frame_start, e);
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      modem_dac_request <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk(dac_enable, 0);
      chk(tx_upmixer_enable, 1);
      chk({rx_rate_select, tx_rate_select}, 0);
      rd(16'h2206, 8'h00);
      rd(16'h2207, 8'hFB);
      rd(16'h2211, 8'h02);
      rd(16'h2212, 8'hA7);
      rd(16'h2213, 8'h02);
      rd(16'h0000, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(16'h2206, {7'h00, i[0]});
         wr(16'h2207, {5'h1F, i[2:1], i[1]});
         modem_dac_request <= i[2];
         repeat (2) @(posedge clk_sys);
         #1 chk(tx_upmixer_enable, |i[2:1]);
         chk(dac_enable, (i[0] && i[1]) ? i[2] : !(i[1] && !i[0]));
      end
      for (int v = 0; v < 4; v++) begin
         wr(16'h2211, {v[1:0], v[1:0], 4'h2});
         @(posedge clk_sys);
         #1 chk({rx_rate_select, rx_accept_500k, rx_accept_1m}, {v[1:0], v[1:0] != 0, v[1]});
         chk({tx_rate_select, tx_allow_500k, tx_allow_1m}, {v[1:0], v[1:0] != 0, v[1]});
         rd(16'h2211, {v[1:0], v[1:0], 4'h2});
      end
      tx_run(4'h0);
      tx_run(4'hF);
      rx_case(4'h2, 8, 4'h7, 4'hA, 1);
      rx_case(4'h2, 7, 4'h7, 4'hA, 0);
      rx_case(4'h2, 8, 4'hA, 4'h7, 0);
      rx_case(4'h2, 10, 4'h7, 4'hA, 1);
      rx_case(4'hF, 21, 4'h7, 4'hA, 1);
      rx_case(4'hF, 20, 4'h7, 4'hA, 0);
      report_and_stop();
   end
endmodule // tb
